// >>> ctm_timer.sv
// Compact timer with comparators A and P, compare output and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module ctm_timer #(
    parameter int CNT_W = 16                    // Counter width
) (
    input  wire logic        aclk,              // Clock, 250 MHz
    input  wire logic        aresetn,           // Synchronous reset, active low
    input  wire logic [7:0]  s_axi_awaddr,      // Write address
    input  wire logic        s_axi_awvalid,     // Write address valid
    output logic             s_axi_awready,     // Write address ready
    input  wire logic [31:0] s_axi_wdata,       // Write data
    input  wire logic [3:0]  s_axi_wstrb,       // Write strobes
    input  wire logic        s_axi_wvalid,      // Write data valid
    output logic             s_axi_wready,      // Write data ready
    output logic [1:0]       s_axi_bresp,       // Write response
    output logic             s_axi_bvalid,      // Write response valid
    input  wire logic        s_axi_bready,      // Write response ready
    input  wire logic [7:0]  s_axi_araddr,      // Read address
    input  wire logic        s_axi_arvalid,     // Read address valid
    output logic             s_axi_arready,     // Read address ready
    output logic [31:0]      s_axi_rdata,       // Read data
    output logic [1:0]       s_axi_rresp,       // Read response
    output logic             s_axi_rvalid,      // Read data valid
    input  wire logic        s_axi_rready,      // Read data ready
    output logic             timer_output_pin,  // Timer output level
    output logic             timer_output_en,   // High while block owns the pin
    output logic             irq                // Level interrupt
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0]       ctrl_reg;
    logic             counter_run_reg;
    logic [7:0]       period_value_reg;
    logic [15:0]      match_a_value_reg;
    logic [15:0]      prescale_reg;
    logic [1:0]       status_reg;
    logic [1:0]       mask_reg;
    logic [CNT_W-1:0] count_reg;
    logic [15:0]      div_reg;
    logic             run_d_reg;
    logic             pin_level_reg;

    logic       clear_select;
    logic       pwm_role_swap;
    logic       output_invert;
    logic       initial_output_level;
    logic [1:0] output_action;
    logic [1:0] mode_field;

    assign clear_select         = ctrl_reg[ctm_pkg::CLR_SEL_BIT];
    assign pwm_role_swap        = ctrl_reg[ctm_pkg::ROLE_SWAP_BIT];
    assign output_invert        = ctrl_reg[ctm_pkg::INVERT_BIT];
    assign initial_output_level = ctrl_reg[ctm_pkg::INIT_LVL_BIT];
    assign output_action        = ctrl_reg[ctm_pkg::ACTION_LSB +: 2];
    assign mode_field           = ctrl_reg[ctm_pkg::MODE_LSB +: 2];

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    logic       aw_held_reg;
    logic       w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic       wr_fire;

    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ctm_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_known(aw_addr_reg) ? ctm_pkg::RESP_OKAY
                                                        : ctm_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a[1:0] == 2'h0) && (a <= ctm_pkg::PRESCALE_OFF);
    endfunction : addr_known

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = wr_fire && (aw_addr_reg == off);
    endfunction : wr_hit

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg          <= ctm_pkg::CTRL1_RST;
            counter_run_reg   <= 1'b0;
            period_value_reg  <= ctm_pkg::PERIOD_RST;
            match_a_value_reg <= ctm_pkg::MATCH_A_RST;
            prescale_reg      <= ctm_pkg::PRESCALE_RST;
            mask_reg          <= 2'h0;
        end else begin
            if (wr_hit(ctm_pkg::CTRL0_OFF) && w_strb_reg[0])
                counter_run_reg <= w_data_reg[ctm_pkg::RUN_BIT];
            if (wr_hit(ctm_pkg::CTRL1_OFF) && w_strb_reg[0])
                ctrl_reg <= w_data_reg[7:0];
            if (wr_hit(ctm_pkg::PERIOD_OFF) && w_strb_reg[0])
                period_value_reg <= w_data_reg[7:0];
            if (wr_hit(ctm_pkg::MATCH_A_OFF)) begin
                if (w_strb_reg[0])
                    match_a_value_reg[7:0] <= w_data_reg[7:0];
                if (w_strb_reg[1])
                    match_a_value_reg[15:8] <= w_data_reg[15:8];
            end
            if (wr_hit(ctm_pkg::PRESCALE_OFF)) begin
                if (w_strb_reg[0])
                    prescale_reg[7:0] <= w_data_reg[7:0];
                if (w_strb_reg[1])
                    prescale_reg[15:8] <= w_data_reg[15:8];
            end
            if (wr_hit(ctm_pkg::MASK_OFF) && w_strb_reg[0])
                mask_reg <= w_data_reg[1:0];
        end
    end

    // ****************************************************************
    // Timer clock divider and counter
    // ****************************************************************
    logic run_rise;
    logic tick;

    assign run_rise = counter_run_reg && !run_d_reg;
    assign tick     = counter_run_reg && (div_reg == prescale_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn || run_rise || !counter_run_reg || tick)
            div_reg <= 16'h0000;
        else
            div_reg <= div_reg + 16'h0001;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            run_d_reg <= 1'b0;
        else
            run_d_reg <= counter_run_reg;
    end

    // Comparator events, judged on the count about to be left
    logic is_pwm;
    logic p_match;
    logic a_match;
    logic overflow;
    logic p_clears;
    logic a_clears;
    logic flag_a_evt;
    logic flag_p_evt;

    assign is_pwm   = (mode_field == ctm_pkg::MODE_PWM);
    // Period match at the last count of n*256 counts, zero gives 65536
    assign p_match  = (count_reg[15:8] == period_value_reg - 8'h01)
                    && (count_reg[7:0] == 8'hFF);
    assign a_match  = (match_a_value_reg != ctm_pkg::MATCH_A_RST)
                    && (count_reg == match_a_value_reg);
    assign overflow = (count_reg == ctm_pkg::COUNT_MAX);

    always_comb begin
        if (is_pwm) begin
            // Role swap picks which comparator sets the period
            p_clears = !pwm_role_swap && (p_match || (period_value_reg == 8'h00
                       && overflow));
            a_clears = pwm_role_swap && a_match;
        end else begin
            p_clears = !clear_select && (p_match || (period_value_reg == 8'h00
                       && overflow));
            a_clears = clear_select && a_match;
        end
    end

    assign flag_a_evt = tick && a_match;
    assign flag_p_evt = tick && p_match && (is_pwm || !clear_select);

    always_ff @(posedge aclk) begin
        if (!aresetn || run_rise)
            count_reg <= '0;
        else if (tick) begin
            if (p_clears || a_clears)
                count_reg <= '0;
            else
                count_reg <= count_reg + CNT_W'(1);
        end
    end

    // ****************************************************************
    // Output pin
    // ****************************************************************
    logic duty_on;

    // Duty active while count below the duty value
    assign duty_on = pwm_role_swap ? ({8'h00, count_reg[15:8]} < {8'h00, period_value_reg})
                                     || (period_value_reg == 8'h00)
                                   : (count_reg < match_a_value_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn)
            pin_level_reg <= 1'b0;
        else if (run_rise)
            pin_level_reg <= initial_output_level;
        else if (flag_a_evt && !is_pwm) begin
            case (output_action)
                ctm_pkg::ACT_LOW:    pin_level_reg <= 1'b0;
                ctm_pkg::ACT_HIGH:   pin_level_reg <= 1'b1;
                ctm_pkg::ACT_TOGGLE: pin_level_reg <= !pin_level_reg;
                default:             pin_level_reg <= pin_level_reg;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_output_pin <= 1'b0;
            timer_output_en  <= 1'b0;
        end else begin
            case (mode_field)
                ctm_pkg::MODE_COMPARE: begin
                    timer_output_pin <= pin_level_reg ^ output_invert;
                    timer_output_en  <= 1'b1;
                end
                ctm_pkg::MODE_PWM: begin
                    timer_output_en <= 1'b1;
                    if (output_action == ctm_pkg::ACT_TOGGLE)
                        timer_output_pin <= (duty_on ~^ initial_output_level)
                                            ^ output_invert;
                    else if (output_action == ctm_pkg::ACT_HIGH)
                        timer_output_pin <= !initial_output_level ^ output_invert;
                    else
                        timer_output_pin <= initial_output_level ^ output_invert;
                end
                default: begin
                    timer_output_pin <= 1'b0;
                    timer_output_en  <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Status, mask and interrupt
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn)
            status_reg <= 2'h0;
        else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_hit(ctm_pkg::STATUS_OFF) && w_strb_reg[0] && w_data_reg[i])
                    status_reg[i] <= 1'b0;
                if ((i == ctm_pkg::FLAG_A_BIT && flag_a_evt)
                    || (i == ctm_pkg::FLAG_P_BIT && flag_p_evt))
                    status_reg[i] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= |(status_reg & mask_reg);
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= ctm_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= addr_known(s_axi_araddr) ? ctm_pkg::RESP_OKAY
                                                         : ctm_pkg::RESP_SLVERR;
                case (s_axi_araddr)
                    ctm_pkg::CTRL0_OFF:    s_axi_rdata <= {31'h0, counter_run_reg};
                    ctm_pkg::CTRL1_OFF:    s_axi_rdata <= {24'h0, ctrl_reg};
                    ctm_pkg::PERIOD_OFF:   s_axi_rdata <= {24'h0, period_value_reg};
                    ctm_pkg::MATCH_A_OFF:  s_axi_rdata <= {16'h0, match_a_value_reg};
                    ctm_pkg::COUNT_OFF:    s_axi_rdata <= {16'h0, count_reg[15:0]};
                    ctm_pkg::STATUS_OFF:   s_axi_rdata <= {30'h0, status_reg};
                    ctm_pkg::MASK_OFF:     s_axi_rdata <= {30'h0, mask_reg};
                    ctm_pkg::PRESCALE_OFF: s_axi_rdata <= {16'h0, prescale_reg};
                    default:               s_axi_rdata <= 32'h00000000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : ctm_timer
`default_nettype wire

// >>> ctm_pkg.sv
// Package of constants for the compact timer compare block
package ctm_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL0_OFF    = 8'h00;
    localparam logic [7:0] CTRL1_OFF    = 8'h04;
    localparam logic [7:0] PERIOD_OFF   = 8'h08;
    localparam logic [7:0] MATCH_A_OFF  = 8'h0C;
    localparam logic [7:0] COUNT_OFF    = 8'h10;
    localparam logic [7:0] STATUS_OFF   = 8'h14;
    localparam logic [7:0] MASK_OFF     = 8'h18;
    localparam logic [7:0] PRESCALE_OFF = 8'h1C;
    // Control one field positions
    localparam int CLR_SEL_BIT   = 0;
    localparam int ROLE_SWAP_BIT = 1;
    localparam int INVERT_BIT    = 2;
    localparam int INIT_LVL_BIT  = 3;
    localparam int ACTION_LSB    = 4;
    localparam int MODE_LSB      = 6;
    // Control zero field positions
    localparam int RUN_BIT       = 0;
    // Status / mask field positions
    localparam int FLAG_A_BIT    = 0;
    localparam int FLAG_P_BIT    = 1;
    // Reset values and counter maximum
    localparam logic [7:0]  CTRL1_RST    = 8'h00;
    localparam logic [7:0]  PERIOD_RST   = 8'h00;
    localparam logic [15:0] MATCH_A_RST  = 16'h0000;
    localparam logic [15:0] PRESCALE_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
    // Mode field encodings
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_PWM     = 2'h2;
    localparam logic [1:0] MODE_TIMER   = 2'h3;
    // Output action encodings
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ctm_pkg

// >>> ctm_timer_checker.sv
// Bus handshake and read response checker for the compact timer
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_checker (
    input wire logic        aclk,           // Clock
    input wire logic        aresetn,        // Reset, active low
    input wire logic        s_axi_awvalid,  // Write address valid
    input wire logic        s_axi_awready,  // Write address ready
    input wire logic        s_axi_wvalid,   // Write data valid
    input wire logic        s_axi_wready,   // Write data ready
    input wire logic        s_axi_bvalid,   // Write response valid
    input wire logic        s_axi_bready,   // Write response ready
    input wire logic [7:0]  s_axi_araddr,   // Read address
    input wire logic        s_axi_arvalid,  // Read address valid
    input wire logic        s_axi_arready,  // Read address ready
    input wire logic [31:0] s_axi_rdata,    // Read data
    input wire logic [1:0]  s_axi_rresp,    // Read response
    input wire logic        s_axi_rvalid,   // Read data valid
    input wire logic        s_axi_rready    // Read data ready
);
    // ****
    // Address of the read in flight
    // ****
    logic [7:0] rd_addr_reg;
    logic       rd_bad;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr_reg <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_reg <= s_axi_araddr;
        end
    end
    assign rd_bad = (rd_addr_reg[1:0] != 2'h0) || (rd_addr_reg > ctm_pkg::PRESCALE_OFF);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****
    // Assertions
    // ****
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready high two cycles");
    w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready high two cycles");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready high two cycles");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped before bready");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    unmapped_read_a: assert property (s_axi_rvalid && rd_bad |->
        s_axi_rresp == ctm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    count_read_a: assert property (s_axi_rvalid && rd_addr_reg == ctm_pkg::COUNT_OFF |->
        s_axi_rdata[31:16] == 16'h0 && s_axi_rresp == ctm_pkg::RESP_OKAY)
        else $error("count read wider than sixteen bits");
endmodule : ctm_timer_checker
`default_nettype wire

// >>> testbench.sv
// Register level test of the compact timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic pin, en, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp, rsp, act;
    logic init, inv, xp;
    int mismatches = 0, n_compared = 0, hi, i;
    always #2 aclk = ~aclk;
    ctm_timer ctm_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_output_pin(pin), .timer_output_en(en), .irq(irq));
    // ****
    // Tasks
    // ****
    task automatic results;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rsp = bresp;
        bready <= 1'b0;
        if (n == 100) begin
            mismatches++;
            results();
        end
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        if (n == 100) begin
            mismatches++;
            results();
        end
    endtask : rdr
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick
    // Stop, load settings, clear flags, then start the counter
    task automatic cfg(input logic [7:0] c1, input logic [7:0] per, input logic [15:0] ma,
                       input logic [1:0] msk);
        wr(ctm_pkg::CTRL0_OFF, 32'h0);
        wr(ctm_pkg::PERIOD_OFF, {24'h0, per});
        wr(ctm_pkg::MATCH_A_OFF, {16'h0, ma});
        wr(ctm_pkg::CTRL1_OFF, {24'h0, c1});
        wr(ctm_pkg::MASK_OFF, {30'h0, msk});
        wr(ctm_pkg::STATUS_OFF, 32'h3);
        wr(ctm_pkg::CTRL0_OFF, 32'h1);
    endtask : cfg
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            rdr(8'h04 * i[7:0]);
            check(rd, 32'h0);
        end
        wr(ctm_pkg::CTRL1_OFF, 32'hA5);
        rdr(ctm_pkg::CTRL1_OFF);
        check(rd, 32'hA5);
        rdr(8'h20);
        check({30'h0, rsp}, {30'h0, ctm_pkg::RESP_SLVERR});
        wr(8'h22, 32'hFF);
        check({30'h0, rsp}, {30'h0, ctm_pkg::RESP_SLVERR});
        for (i = 0; i < 4; i++) begin
            act = i[1:0];
            init = (act != ctm_pkg::ACT_HIGH);
            inv = i[0];
            xp = (act == ctm_pkg::ACT_NONE) ? init : (act == ctm_pkg::ACT_LOW) ? 1'b0 :
                 (act == ctm_pkg::ACT_HIGH) ? 1'b1 : ~init;
            cfg({ctm_pkg::MODE_COMPARE, act, init, inv, 2'b01}, 8'h01, 16'd600, 2'h0);
            tick(4);
            check({31'h0, pin}, {31'h0, init ^ inv});
            check({31'h0, en}, 32'h1);
            tick(700);
            check({31'h0, pin}, {31'h0, xp ^ inv});
            rdr(ctm_pkg::STATUS_OFF);
            check(rd, 32'h1);
            rdr(ctm_pkg::COUNT_OFF);
            check({31'h0, rd <= 32'd600}, 32'h1);
        end
        cfg({ctm_pkg::MODE_COMPARE, ctm_pkg::ACT_HIGH, 4'h0}, 8'h01, 16'd100, 2'h2);
        tick(300);
        rdr(ctm_pkg::STATUS_OFF);
        check(rd, 32'h3);
        rdr(ctm_pkg::COUNT_OFF);
        check({31'h0, rd <= 32'd255}, 32'h1);
        check({31'h0, pin}, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr(ctm_pkg::MASK_OFF, 32'h0);
        tick(2);
        check({31'h0, irq}, 32'h0);
        wr(ctm_pkg::MASK_OFF, 32'h2);
        tick(2);
        check({31'h0, irq}, 32'h1);
        wr(ctm_pkg::CTRL0_OFF, 32'h0);
        wr(ctm_pkg::STATUS_OFF, 32'h3);
        tick(2);
        check({31'h0, irq}, 32'h0);
        cfg({ctm_pkg::MODE_COMPARE, 6'h0}, 8'h00, 16'd0, 2'h0);
        tick(300);
        rdr(ctm_pkg::COUNT_OFF);
        check({31'h0, rd > 32'd255}, 32'h1);
        cfg({ctm_pkg::MODE_COMPARE, ctm_pkg::ACT_TOGGLE, 4'h1}, 8'h01, 16'd0, 2'h0);
        tick(66000);
        rdr(ctm_pkg::STATUS_OFF);
        check(rd, 32'h0);
        check({31'h0, pin}, 32'h0);
        rdr(ctm_pkg::COUNT_OFF);
        check({31'h0, rd < 32'h1000}, 32'h1);
        cfg({ctm_pkg::MODE_TIMER, ctm_pkg::ACT_TOGGLE, 4'hD}, 8'h00, 16'd100, 2'h0);
        tick(150);
        check({31'h0, en}, 32'h0);
        check({31'h0, pin}, 32'h0);
        rdr(ctm_pkg::STATUS_OFF);
        check(rd, 32'h1);
        for (i = 0; i < 2; i++) begin
            cfg({ctm_pkg::MODE_PWM, ctm_pkg::ACT_TOGGLE, 2'b10, i[0], 1'b1}, 8'h01,
                i[0] ? 16'd511 : 16'd128, 2'h0);
            tick(20);
            check({31'h0, en}, 32'h1);
            hi = 0;
            repeat (512) begin
                @(posedge aclk);
                hi += int'(pin);
            end
            check(hi, 32'd256);
        end
        wr(ctm_pkg::PRESCALE_OFF, 32'h1);
        cfg({ctm_pkg::MODE_COMPARE, 6'h0}, 8'h00, 16'd0, 2'h0);
        tick(200);
        rdr(ctm_pkg::COUNT_OFF);
        check({31'h0, rd >= 32'd100 && rd <= 32'd102}, 32'h1);
        results();
    end
endmodule : testbench
bind ctm_timer ctm_timer_checker ctm_timer_checker_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
`default_nettype wire
